// ### hw/rpaeq_pkg.sv
package rpaeq_pkg;
    localparam int NPORT = 4;
    localparam int CNT_W = 24;
    localparam int DLY_W = 6;
    localparam int EQ_W = 4;
    // register offsets
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
    localparam logic [7:0] ADDR_EQ_CTL = 8'hD2;
    localparam logic [7:0] ADDR_EQ_STAT = 8'hD3;
    localparam logic [7:0] ADDR_EQ_MAN = 8'hD4;
    localparam logic [7:0] ADDR_EQ_LIM = 8'hD5;
    localparam logic [7:0] ADDR_FILT_CLK = 8'hD6;
    localparam logic [7:0] ADDR_FILT_DAT = 8'hD7;
    // field positions
    localparam int CTL_RELOCK_LSB = 5;
    localparam int CTL_FIRST_BIT = 4;
    localparam int CTL_RESTART_BIT = 3;
    localparam int CTL_FLOOR_BIT = 2;
    localparam int MAN_UPPER_LSB = 5;
    localparam int MAN_MODE_BIT = 4;
    localparam int MAN_LOWER_LSB = 1;
    localparam int MAN_EN_BIT = 0;
    localparam int LIM_CEIL_LSB = 4;
    localparam int LIM_FLOOR_LSB = 0;
    localparam int FILT_TOP_BIT = 7;
    localparam int FILT_MID_BIT = 6;
    // reset values
    localparam logic [7:0] PORT_SEL_RST = 8'h01;
    localparam logic [2:0] RELOCK_RST = 3'h4;
    localparam logic FIRST_LOCK_RST = 1'b1;
    localparam logic FLOOR_EN_RST = 1'b1;
    localparam logic [2:0] MAN_UPPER_RST = 3'h3;
    localparam logic [2:0] MAN_LOWER_RST = 3'h0;
    localparam logic LOCK_MODE_RST = 1'b0;
    localparam logic MAN_EN_RST = 1'b0;
    localparam logic [3:0] CEIL_RST = 4'hF;
    localparam logic [3:0] FLOOR_RST = 4'h2;
    // relock timing at the 40 MHz core clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int RELOCK_BASE_NS = 164000;
    localparam int RELOCK_BASE_CYC = (RELOCK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [2:0] relock_wait_code;
        logic first_lock_restart_en;
        logic floor_start_en;
        logic [2:0] manual_eq_upper;
        logic lock_needs_eq_done;
        logic [2:0] manual_eq_lower;
        logic eq_manual_en;
        logic [3:0] eq_ceiling;
        logic [3:0] eq_start_floor;
    } rpaeq_cfg_t;

    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] rd_port;
        logic [3:0] wr_en;
    } rpaeq_sel_t;

    typedef struct packed {
        logic filt_at_limit;
        logic filt_settled;
        logic filt_meas_fault;
    } rpaeq_flag_t;

    typedef enum logic [1:0] {
        ST_SEARCH = 2'h0,
        ST_LOCKED = 2'h1,
        ST_MANUAL = 2'h3
    } rpaeq_state_t;
endpackage : rpaeq_pkg

// ### hw/rpaeq_top.sv
`timescale 1ns/1ps
module rpaeq_top
    import rpaeq_pkg::*;
#(
    parameter int RELOCK_BASE_CYCLES = RELOCK_BASE_CYC
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // receiver and filter status per port
    input wire logic [NPORT-1:0] RX_LOCK,
    input wire logic [NPORT-1:0] FILT_LIMIT_EVT,
    input wire logic [NPORT-1:0] FILT_STABLE,
    input wire logic [NPORT-1:0] FILT_FAULT_EVT,
    input wire logic [NPORT*DLY_W-1:0] FILT_CLK_DELAY,
    input wire logic [NPORT*DLY_W-1:0] FILT_DATA_DELAY,
    // equalizer control per port
    output logic [NPORT*DLY_W-1:0] EQ_SETTING,
    output logic [NPORT-1:0] LOCK_STS
);

    // address compare shared by write and read decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : reg_hit

    // relock wait in cycles, doubling per code step
    function automatic logic [CNT_W-1:0] relock_limit(input logic [2:0] code);
        return CNT_W'(RELOCK_BASE_CYCLES) << code;
    endfunction : relock_limit

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    rpaeq_sel_t sel_q, sel_d;
    rpaeq_cfg_t cfg_q [NPORT];
    rpaeq_cfg_t cfg_d [NPORT];
    rpaeq_flag_t flag_q [NPORT];
    rpaeq_flag_t flag_d [NPORT];
    rpaeq_state_t st_q [NPORT];
    rpaeq_state_t st_d [NPORT];
    logic [EQ_W-1:0] eq_q [NPORT];
    logic [EQ_W-1:0] eq_d [NPORT];
    logic [EQ_W-1:0] start [NPORT];
    logic [CNT_W-1:0] cnt_q [NPORT];
    logic [CNT_W-1:0] cnt_d [NPORT];
    logic [CNT_W-1:0] limit [NPORT];
    logic seen_q [NPORT];
    logic seen_d [NPORT];
    logic [DLY_W-1:0] eq_out_q [NPORT];
    logic [DLY_W-1:0] eq_out_d [NPORT];
    logic [NPORT-1:0] lock_q, lock_d;
    logic [NPORT-1:0] wr_hit, restart_hit, clr_clk, clr_dat;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // page select register
    always_comb begin
        sel_d = sel_q;
        if (REG_WR && reg_hit(REG_ADDR, ADDR_PORT_SEL)) begin
            sel_d = rpaeq_sel_t'(REG_WDATA);
            sel_d.unused = 2'h0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sel_q <= rpaeq_sel_t'(PORT_SEL_RST);
        end else begin
            sel_q <= sel_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NPORT; i++) begin : g_port
            assign wr_hit[i] = REG_WR && sel_q.wr_en[i];
            // restart is a strobe, never stored
            assign restart_hit[i] = wr_hit[i] && reg_hit(REG_ADDR, ADDR_EQ_CTL)
                && REG_WDATA[CTL_RESTART_BIT];
            // read side effects only on read page
            assign clr_clk[i] = REG_RD && reg_hit(REG_ADDR, ADDR_FILT_CLK)
                && (sel_q.rd_port == 2'(i));
            assign clr_dat[i] = REG_RD && reg_hit(REG_ADDR, ADDR_FILT_DAT)
                && (sel_q.rd_port == 2'(i));
            assign start[i] = !cfg_q[i].floor_start_en ? 4'h0 :
                (cfg_q[i].eq_start_floor > cfg_q[i].eq_ceiling) ? cfg_q[i].eq_ceiling :
                cfg_q[i].eq_start_floor;
            assign limit[i] = relock_limit(cfg_q[i].relock_wait_code);

            // configuration registers of this port
            always_comb begin
                cfg_d[i] = cfg_q[i];
                if (wr_hit[i] && reg_hit(REG_ADDR, ADDR_EQ_CTL)) begin
                    cfg_d[i].relock_wait_code = REG_WDATA[CTL_RELOCK_LSB +: 3];
                    cfg_d[i].first_lock_restart_en = REG_WDATA[CTL_FIRST_BIT];
                    cfg_d[i].floor_start_en = REG_WDATA[CTL_FLOOR_BIT];
                end
                if (wr_hit[i] && reg_hit(REG_ADDR, ADDR_EQ_MAN)) begin
                    cfg_d[i].manual_eq_upper = REG_WDATA[MAN_UPPER_LSB +: 3];
                    cfg_d[i].lock_needs_eq_done = REG_WDATA[MAN_MODE_BIT];
                    cfg_d[i].manual_eq_lower = REG_WDATA[MAN_LOWER_LSB +: 3];
                    cfg_d[i].eq_manual_en = REG_WDATA[MAN_EN_BIT];
                end
                if (wr_hit[i] && reg_hit(REG_ADDR, ADDR_EQ_LIM)) begin
                    cfg_d[i].eq_ceiling = REG_WDATA[LIM_CEIL_LSB +: 4];
                    cfg_d[i].eq_start_floor = REG_WDATA[LIM_FLOOR_LSB +: 4];
                end
            end

            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    cfg_q[i] <= '{RELOCK_RST, FIRST_LOCK_RST, FLOOR_EN_RST, MAN_UPPER_RST,
                        LOCK_MODE_RST, MAN_LOWER_RST, MAN_EN_RST, CEIL_RST, FLOOR_RST};
                end else begin
                    cfg_q[i] <= cfg_d[i];
                end
            end

            // filter status flags, set wins over read clear
            always_comb begin
                flag_d[i].filt_at_limit = FILT_LIMIT_EVT[i]
                    || (flag_q[i].filt_at_limit && !clr_clk[i]);
                // latched low, read loads current stability
                flag_d[i].filt_settled = clr_clk[i] ? FILT_STABLE[i]
                    : (flag_q[i].filt_settled && FILT_STABLE[i]);
                flag_d[i].filt_meas_fault = FILT_FAULT_EVT[i]
                    || (flag_q[i].filt_meas_fault && !clr_dat[i]);
            end

            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    flag_q[i] <= '0;
                end else begin
                    flag_q[i] <= flag_d[i];
                end
            end

            // adaptation state machine
            always_comb begin
                st_d[i] = st_q[i];
                eq_d[i] = eq_q[i];
                cnt_d[i] = '0;
                seen_d[i] = seen_q[i];
                if (cfg_q[i].eq_manual_en) begin
                    st_d[i] = ST_MANUAL;
                end else if (restart_hit[i]) begin
                    st_d[i] = ST_SEARCH;
                    eq_d[i] = start[i];
                end else begin
                    unique case (st_q[i])
                        ST_SEARCH: begin
                            cnt_d[i] = cnt_q[i] + 24'h1;
                            if (RX_LOCK[i] && cfg_q[i].first_lock_restart_en && !seen_q[i]) begin
                                seen_d[i] = 1'b1;
                                eq_d[i] = 4'h0;
                                cnt_d[i] = '0;
                            end else if (RX_LOCK[i]) begin
                                seen_d[i] = 1'b1;
                                st_d[i] = ST_LOCKED;
                            end else if (eq_q[i] > cfg_q[i].eq_ceiling) begin
                                eq_d[i] = start[i];
                                cnt_d[i] = '0;
                            end else if (cnt_q[i] >= limit[i] - 24'h1) begin
                                cnt_d[i] = '0;
                                // wrap to start at the ceiling
                                if (eq_q[i] >= cfg_q[i].eq_ceiling) begin
                                    eq_d[i] = start[i];
                                end else begin
                                    eq_d[i] = eq_q[i] + 4'h1;
                                end
                            end
                        end
                        ST_LOCKED: begin
                            if (!RX_LOCK[i]) begin
                                st_d[i] = ST_SEARCH;
                            end
                        end
                        ST_MANUAL: begin
                            st_d[i] = ST_SEARCH;
                            eq_d[i] = start[i];
                        end
                        default: begin
                            st_d[i] = ST_SEARCH;
                        end
                    endcase
                end
                // a new wait code restarts the wait
                if (wr_hit[i] && reg_hit(REG_ADDR, ADDR_EQ_CTL)) begin
                    cnt_d[i] = '0; // never left above a shorter limit
                end
                eq_out_d[i] = cfg_q[i].eq_manual_en
                    ? {cfg_q[i].manual_eq_upper, cfg_q[i].manual_eq_lower}
                    : {2'h0, eq_d[i]};
                lock_d[i] = RX_LOCK[i] && (!cfg_q[i].lock_needs_eq_done || st_q[i] != ST_SEARCH);
            end

            always_ff @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    st_q[i] <= ST_SEARCH;
                    eq_q[i] <= 4'h0;
                    cnt_q[i] <= '0;
                    seen_q[i] <= 1'b0;
                    eq_out_q[i] <= 6'h00;
                    lock_q[i] <= 1'b0;
                end else begin
                    st_q[i] <= st_d[i];
                    eq_q[i] <= eq_d[i];
                    cnt_q[i] <= cnt_d[i];
                    seen_q[i] <= seen_d[i];
                    eq_out_q[i] <= eq_out_d[i];
                    lock_q[i] <= lock_d[i];
                end
            end

            assign EQ_SETTING[i*DLY_W +: DLY_W] = eq_out_q[i];

            // timeout while searching, not disturbed
            sequence s_timeout;
                st_q[i] == ST_SEARCH && !RX_LOCK[i] && !cfg_q[i].eq_manual_en
                    && !restart_hit[i] && cnt_q[i] == limit[i] - 24'h1;
            endsequence

            // counter stays below the wait time
            a_relock_bound: assert property (st_q[i] == ST_SEARCH |-> cnt_q[i] < limit[i])
                else $error("relock counter past wait time");
            a_step_on_wait: assert property (s_timeout ##0 (eq_q[i] < cfg_q[i].eq_ceiling)
                |=> eq_q[i] == $past(eq_q[i]) + 4'h1)
                else $error("no step after relock wait");
            a_wrap_start: assert property (s_timeout ##0 (eq_q[i] == cfg_q[i].eq_ceiling)
                |=> eq_q[i] == $past(start[i]))
                else $error("no return to start at ceiling");
            a_first_lock: assert property (st_q[i] == ST_SEARCH && RX_LOCK[i]
                && cfg_q[i].first_lock_restart_en && !seen_q[i] && !cfg_q[i].eq_manual_en
                && !restart_hit[i] |=> eq_q[i] == 4'h0 && seen_q[i] ##1 seen_q[i])
                else $error("first lock did not restart at zero");
            a_restart_start: assert property (restart_hit[i] && !cfg_q[i].eq_manual_en
                |=> st_q[i] == ST_SEARCH && eq_q[i] == $past(start[i]))
                else $error("restart did not reload start");
            a_eq_ceiling: assert property ($stable(cfg_q[i].eq_ceiling) && st_q[i] == ST_SEARCH
                && $past(st_q[i]) == ST_SEARCH |-> eq_q[i] <= cfg_q[i].eq_ceiling)
                else $error("setting above ceiling");
            a_bypass_hold: assert property (cfg_q[i].eq_manual_en |=> st_q[i] == ST_MANUAL
                && $stable(eq_q[i]))
                else $error("adaptation ran in bypass");
            a_bypass_value: assert property ($past(cfg_q[i].eq_manual_en) && $stable(cfg_q[i])
                |-> eq_out_q[i] == {cfg_q[i].manual_eq_upper, cfg_q[i].manual_eq_lower})
                else $error("bypass setting not applied");
            a_lock_mode: assert property (cfg_q[i].lock_needs_eq_done && st_q[i] == ST_SEARCH
                |=> !lock_q[i])
                else $error("lock reported before adaptation done");
            a_limit_flag: assert property ((FILT_LIMIT_EVT[i] |=> flag_q[i].filt_at_limit)
                and (clr_clk[i] && !FILT_LIMIT_EVT[i] |=> !flag_q[i].filt_at_limit))
                else $error("limit flag wrong");
            a_settled_low: assert property (!FILT_STABLE[i] ##1 !clr_clk[i] [*2]
                |-> !flag_q[i].filt_settled)
                else $error("settled flag not latched low");
            a_fault_flag: assert property (FILT_FAULT_EVT[i] ##1 !clr_dat[i]
                |=> flag_q[i].filt_meas_fault)
                else $error("fault flag lost before read");
            a_write_steer: assert property (REG_WR && !sel_q.wr_en[i] |=> $stable(cfg_q[i]))
                else $error("write reached a disabled port");
        end
    endgenerate

    // read mux from the read page
    always_comb begin
        rdata_d = 8'h00;
        rvalid_d = REG_RD;
        if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_PORT_SEL: rdata_d = sel_q;
                ADDR_EQ_CTL: begin
                    rdata_d[CTL_RELOCK_LSB +: 3] = cfg_q[sel_q.rd_port].relock_wait_code;
                    rdata_d[CTL_FIRST_BIT] = cfg_q[sel_q.rd_port].first_lock_restart_en;
                    rdata_d[CTL_FLOOR_BIT] = cfg_q[sel_q.rd_port].floor_start_en;
                end
                ADDR_EQ_STAT: rdata_d = {2'h0, eq_out_q[sel_q.rd_port]};
                ADDR_EQ_MAN: begin
                    rdata_d[MAN_UPPER_LSB +: 3] = cfg_q[sel_q.rd_port].manual_eq_upper;
                    rdata_d[MAN_MODE_BIT] = cfg_q[sel_q.rd_port].lock_needs_eq_done;
                    rdata_d[MAN_LOWER_LSB +: 3] = cfg_q[sel_q.rd_port].manual_eq_lower;
                    rdata_d[MAN_EN_BIT] = cfg_q[sel_q.rd_port].eq_manual_en;
                end
                ADDR_EQ_LIM: rdata_d = {cfg_q[sel_q.rd_port].eq_ceiling,
                    cfg_q[sel_q.rd_port].eq_start_floor};
                ADDR_FILT_CLK: begin
                    rdata_d[FILT_TOP_BIT] = flag_q[sel_q.rd_port].filt_at_limit;
                    rdata_d[FILT_MID_BIT] = flag_q[sel_q.rd_port].filt_settled;
                    rdata_d[DLY_W-1:0] = FILT_CLK_DELAY[sel_q.rd_port*DLY_W +: DLY_W];
                end
                ADDR_FILT_DAT: begin
                    rdata_d[FILT_MID_BIT] = flag_q[sel_q.rd_port].filt_meas_fault;
                    rdata_d[DLY_W-1:0] = FILT_DATA_DELAY[sel_q.rd_port*DLY_W +: DLY_W];
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign LOCK_STS = lock_q;

    // status read comes from read page
    a_read_page: assert property (REG_RD && reg_hit(REG_ADDR, ADDR_EQ_STAT)
        |=> REG_RVALID && REG_RDATA == {2'h0, $past(eq_out_q[sel_q.rd_port])})
        else $error("status read from wrong port");
    a_restart_zero: assert property (REG_RD && reg_hit(REG_ADDR, ADDR_EQ_CTL)
        |=> !REG_RDATA[CTL_RESTART_BIT])
        else $error("restart bit read as set");

endmodule : rpaeq_top

// ### dv/rpaeq_host.sv
`timescale 1ns/1ps
module rpaeq_host (
    // clock
    input wire logic CLOCK,
    // register port
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID
);
    // idle bus at time zero
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end
    // one-cycle write strobe, launched at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLOCK);
        REG_WR = 1'b0;
        REG_WDATA = ~d; // stale data never left on the bus
    endtask : wr
    // one-cycle read strobe, data taken while valid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLOCK);
        REG_RD = 1'b0;
        n = 0;
        while (REG_RVALID !== 1'b1 && n < 3) begin
            @(negedge CLOCK);
            n++;
        end
        d = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hXX;
    endtask : rd
endmodule : rpaeq_host

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    import rpaeq_pkg::*;
    localparam int BASE = 8;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, u, w;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [NPORT-1:0] rx_lock, lim_evt, stable, fault_evt, lock_sts;
    logic [NPORT*DLY_W-1:0] cdly, ddly, eq_set;
    logic [3:0] cur;
    logic [2:0] code;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    // clock and hang guard
    always #12.5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    rpaeq_top #(.RELOCK_BASE_CYCLES(BASE)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .RX_LOCK(rx_lock),
        .FILT_LIMIT_EVT(lim_evt), .FILT_STABLE(stable), .FILT_FAULT_EVT(fault_evt),
        .FILT_CLK_DELAY(cdly), .FILT_DATA_DELAY(ddly), .EQ_SETTING(eq_set),
        .LOCK_STS(lock_sts));
    rpaeq_host host (.CLOCK(CLOCK), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // expected adaptive step, wrapping to start at the ceiling
    function automatic logic [3:0] next_eq(input logic [3:0] c, f, m);
        return (c == m) ? f : c + 4'h1;
    endfunction : next_eq
    // falling edges until port 0 setting moves
    task automatic wait_move(output int c);
        logic [5:0] old;
        old = eq_set[5:0];
        c = 0;
        while (eq_set[5:0] === old && c < 2000) begin
            @(negedge CLOCK);
            c++;
        end
    endtask : wait_move
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        {rx_lock, lim_evt, stable, fault_evt} = 16'h0000;
        void'($urandom(34576));
        cdly = 24'($urandom());
        ddly = 24'($urandom());
        repeat (6) @(negedge CLOCK);
        RST_N = 1'b1;
        host.rd(ADDR_EQ_CTL, v);
        chk(v, 8'h94);
        host.rd(ADDR_EQ_MAN, v);
        chk(v, 8'h60);
        host.rd(ADDR_EQ_LIM, v);
        chk(v, 8'hF2);
        host.rd(ADDR_EQ_STAT, v);
        chk(v, 8'h00);
        host.rd(8'hD0, v);
        chk(v, 8'h00);
        host.rd(ADDR_FILT_DAT, v);
        chk(v, {2'h0, ddly[5:0]});
        $display("test reset done");
        code = 3'($urandom_range(0, 2));
        host.wr(ADDR_EQ_LIM, 8'h42);
        host.wr(ADDR_EQ_CTL, {code, 5'h1C});
        n = 0;
        while (eq_set[5:0] !== 6'h02 && n < 50) begin
            @(negedge CLOCK);
            n++;
        end
        chk({2'h0, eq_set[5:0]}, 8'h02);
        cur = 4'h2;
        for (int i = 0; i < 4; i++) begin
            wait_move(n);
            chk(8'(n), 8'(BASE << code));
            cur = next_eq(cur, 4'h2, 4'h4);
            chk({2'h0, eq_set[5:0]}, {4'h0, cur});
        end
        host.rd(ADDR_EQ_CTL, v);
        chk(v, {code, 5'h14});
        $display("test adapt done");
        rx_lock[0] = 1'b1;
        repeat (4) @(negedge CLOCK);
        chk({2'h0, eq_set[5:0]}, 8'h00);
        chk({7'h0, lock_sts[0]}, 8'h01);
        repeat (3 * (BASE << code)) @(negedge CLOCK);
        chk({2'h0, eq_set[5:0]}, 8'h00);
        rx_lock[0] = 1'b0;
        $display("test lock done");
        u = 8'($urandom());
        host.wr(ADDR_EQ_MAN, {u[7:5], 1'b0, u[3:1], 1'b1});
        repeat (40) @(negedge CLOCK);
        chk({2'h0, eq_set[5:0]}, {2'h0, u[7:5], u[3:1]});
        host.rd(ADDR_EQ_STAT, v);
        chk(v, {2'h0, u[7:5], u[3:1]});
        w = 8'($urandom());
        host.wr(ADDR_PORT_SEL, 8'h12);
        host.wr(ADDR_EQ_MAN, {w[7:5], 1'b0, w[3:1], 1'b1});
        repeat (3) @(negedge CLOCK);
        chk({2'h0, eq_set[11:6]}, {2'h0, w[7:5], w[3:1]});
        chk({2'h0, eq_set[5:0]}, {2'h0, u[7:5], u[3:1]});
        host.rd(ADDR_EQ_MAN, v);
        chk(v, {w[7:5], 1'b0, w[3:1], 1'b1});
        host.wr(ADDR_PORT_SEL, 8'h0F);
        host.wr(ADDR_EQ_MAN, 8'h60);
        host.wr(ADDR_PORT_SEL, 8'h01);
        $display("test bypass done");
        lim_evt[0] = 1'b1;
        fault_evt[0] = 1'b1;
        stable[0] = 1'b1;
        @(negedge CLOCK);
        {lim_evt[0], fault_evt[0]} = 2'b00;
        host.rd(ADDR_FILT_CLK, v);
        chk(v, {2'h2, cdly[5:0]});
        host.rd(ADDR_FILT_CLK, v);
        chk(v, {2'h1, cdly[5:0]});
        stable[0] = 1'b0;
        @(negedge CLOCK);
        stable[0] = 1'b1;
        host.rd(ADDR_FILT_CLK, v);
        chk(v, {2'h0, cdly[5:0]});
        host.rd(ADDR_FILT_CLK, v);
        chk(v, {2'h1, cdly[5:0]});
        host.rd(ADDR_FILT_DAT, v);
        chk(v, {2'h1, ddly[5:0]});
        host.rd(ADDR_FILT_DAT, v);
        chk(v, {2'h0, ddly[5:0]});
        $display("test filter done");
        // lock held off until adaptation is done
        host.wr(ADDR_EQ_MAN, 8'h70);
        rx_lock[0] = 1'b1;
        @(negedge CLOCK);
        chk({7'h0, lock_sts[0]}, 8'h00);
        @(negedge CLOCK);
        chk({7'h0, lock_sts[0]}, 8'h01);
        rx_lock[0] = 1'b0;
        // floor off, then restart from zero
        host.wr(ADDR_EQ_CTL, {code, 5'h10});
        host.wr(ADDR_EQ_CTL, {code, 5'h18});
        chk({2'h0, eq_set[5:0]}, 8'h00);
        wait_move(n);
        chk(8'(n), 8'(BASE << code));
        chk({2'h0, eq_set[5:0]}, 8'h01);
        $display("test lock mode done");
        end_sim();
    end
endmodule : tb
